// ==== data_memory_decode.sv ====
// Data space decoder: internal RAM, SPECIAL_FUNCTION_REGISTER, banks, bits and external-move routing
`timescale 1ns/1ps
module data_memory_decode (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_has_can,
    input wire dmem_pkg::int_req_t i_int_req,
    input wire dmem_pkg::ext_req_t i_ext_req,
    input wire logic [7:0] i_program_status_word,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sp_push,
    input wire logic i_sp_pop,
    input wire logic [7:0] i_ext_rdata,
    input wire logic [7:0] i_p2_latch,
    output logic [7:0] o_sfr_rdata,
    output dmem_pkg::int_target_t o_int_target,
    output logic [7:0] o_int_ram_addr,
    output logic [2:0] o_int_bit_pos,
    output logic o_int_valid,
    output logic [7:0] o_stack_pointer,
    output dmem_pkg::ext_target_t o_ext_target,
    output logic [15:0] o_ext_addr,
    output logic o_ext_valid,
    output logic o_ext_write,
    output logic o_bus_rd_n,
    output logic o_bus_wr_n,
    output logic o_bus_drive,
    output logic [7:0] o_p0_out,
    output logic [7:0] o_p2_out,
    output logic [7:0] o_ext_rdata,
    output logic o_rdata_undefined
);
    // Complete state of the block
    // Every flop of the block lives here so reset and update stay in one place
    typedef struct packed {
        // Control register bits and page register
        logic global_disable;
        logic visible_access;
        logic [7:0] xdata_page_register;
        // Stack, readback and pointer shadows
        logic [7:0] stack_pointer;
        logic [7:0] sfr_rdata;
        logic [7:0] pointer_zero;
        logic [7:0] pointer_one;
        // Internal decode result
        dmem_pkg::int_target_t int_target;
        logic [7:0] int_ram_addr;
        logic [2:0] int_bit_pos;
        logic int_valid;
        // External routing result
        dmem_pkg::ext_target_t ext_target;
        logic [15:0] ext_addr;
        logic ext_valid;
        logic ext_write;
        // External bus pins and read data
        logic bus_rd_n;
        logic bus_wr_n;
        logic bus_drive;
        logic [7:0] p0_out;
        logic [7:0] p2_out;
        logic [7:0] ext_rdata;
        logic rdata_undefined;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    // Decode results and helpers
    logic [1:0] bank_sel;
    logic [7:0] int_addr_eff;
    logic [15:0] ext_eff_addr;
    logic on_chip;
    dmem_pkg::int_target_t int_target_w;
    logic [7:0] int_ram_w;
    logic [2:0] int_bit_w;
    dmem_pkg::ext_target_t ext_target_w;
    logic bus_cycle;
    logic ext_read_done;
    // SPECIAL_FUNCTION_REGISTER address decode strobes
    logic sysctl_wr;
    logic sysctl_rd;
    logic sp_wr;
    logic page_wr;

    // Active bank from the status word
    // Bank select is read live, so a status word change applies to the next access
    assign bank_sel = {i_program_status_word[dmem_pkg::BANK_SEL_HIGH_POS],
                       i_program_status_word[dmem_pkg::BANK_SEL_LOW_POS]};

    // Pointer register value replaces the address when via_pointer is set
    // Only the two lowest bank registers can serve as pointers
    assign int_addr_eff = !i_int_req.via_pointer ? i_int_req.addr :
                          (i_int_req.pointer_sel ? state_r.pointer_one : state_r.pointer_zero);

    // Effective external address: 16-bit pointer or page plus pointer register
    // The page register supplies the high byte for 8-bit pointer moves
    assign ext_eff_addr = i_ext_req.use_data_pointer_16 ? i_ext_req.data_pointer_16 :
                          {state_r.xdata_page_register, (i_ext_req.pointer_sel ? state_r.pointer_one
                                                                : state_r.pointer_zero)};

    // Internal space decoder: bank, bit and block selection
    int_addr_decode u_int_addr_decode (
        .i_addr(int_addr_eff),
        .i_indirect(i_int_req.indirect),
        .i_bank(bank_sel),
        .i_reg_index(i_int_req.reg_index),
        .i_reg_access(i_int_req.reg_access),
        .i_bit_access(i_int_req.bit_access),
        .o_target(int_target_w),
        .o_ram_addr(int_ram_w),
        .o_bit_pos(int_bit_w)
    );

    // External-move window decoder on the effective address
    ext_addr_decode u_ext_addr_decode (
        .i_addr(ext_eff_addr),
        .i_global_disable(state_r.global_disable),
        .i_has_can(i_has_can),
        .o_target(ext_target_w)
    );

    // On-chip targets are the ONCHIP_XDATA_RAM and CAN windows; the gap counts as neither
    assign on_chip = (ext_target_w == dmem_pkg::XT_ONCHIP_XDATA_RAM) || (ext_target_w == dmem_pkg::XT_CAN);
    // Bus cycle for every off-chip move, and for on-chip ones only when made visible
    assign bus_cycle = (ext_target_w == dmem_pkg::XT_EXTERNAL) || (on_chip && state_r.visible_access);

    // Off-chip read data is captured while the read strobe is low, the cycle after the request
    assign ext_read_done = state_r.ext_valid && !state_r.ext_write && (state_r.ext_target == dmem_pkg::XT_EXTERNAL);

    // Decode of the SPECIAL_FUNCTION_REGISTER addresses served here
    always_comb begin
        sysctl_wr = 1'b0;
        sysctl_rd = 1'b0;
        sp_wr = 1'b0;
        page_wr = 1'b0;
        if (i_sfr_addr == dmem_pkg::SYSCTL_ADDR) begin
            // Control register
            sysctl_wr = i_sfr_wr;
            sysctl_rd = i_sfr_rd;
        end else if (i_sfr_addr == dmem_pkg::STACK_PTR_ADDR) begin
            // Stack pointer
            sp_wr = i_sfr_wr;
        end else if (i_sfr_addr == i_p2_latch) begin
            // Port 2 latch, which also loads the page
            page_wr = i_sfr_wr;
        end
    end

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        // Pulses and strobes drop back to idle unless an access refreshes them
        state_nxt.int_valid = 1'b0;
        state_nxt.ext_valid = 1'b0;
        state_nxt.bus_rd_n = 1'b1;
        state_nxt.bus_wr_n = 1'b1;
        state_nxt.bus_drive = 1'b0;
        state_nxt.rdata_undefined = 1'b0;

        // Control register writes
        // The disable bit can only fall here; a stray write of one never
        // raises it again, so only reset switches the on-chip windows off
        if (sysctl_wr) begin
            state_nxt.visible_access = i_sfr_wdata[dmem_pkg::VISIBLE_ACCESS_BIT];
            if (!i_sfr_wdata[dmem_pkg::GLOBAL_DISABLE_BIT]) begin
                state_nxt.global_disable = 1'b0;
            end
        end

        // Page register tracks port 2 writes
        // A port 2 write also moves the page so that an 8-bit pointer move
        // to an off-chip page cannot land in the on-chip windows by accident
        if (page_wr) begin
            state_nxt.xdata_page_register = i_sfr_wdata;
        end

        // Control register readback, reserved bits undefined (read as ones)
        // Disable and visible bits read back live; all other bits read as ones
        if (sysctl_rd) begin
            state_nxt.sfr_rdata = dmem_pkg::SYSCTL_RESERVED_READ;
            state_nxt.sfr_rdata[dmem_pkg::GLOBAL_DISABLE_BIT] = state_r.global_disable;
            state_nxt.sfr_rdata[dmem_pkg::VISIBLE_ACCESS_BIT] = state_r.visible_access;
        end

        // Stack pointer moves anywhere across the 256-byte space
        // Push and pop wrap modulo 256; a software write overrides both strobes
        if (sp_wr) begin
            state_nxt.stack_pointer = i_sfr_wdata;
        end else if (i_sp_push && !i_sp_pop) begin
            state_nxt.stack_pointer = state_r.stack_pointer + 8'h01;
        end else if (i_sp_pop && !i_sp_push) begin
            state_nxt.stack_pointer = state_r.stack_pointer - 8'h01;
        end

        // Internal access decode into three distinct blocks
        if (i_int_req.valid) begin
            // Decode is registered, so the answer follows one cycle after the request
            state_nxt.int_valid = 1'b1;
            state_nxt.int_target = int_target_w;
            state_nxt.int_ram_addr = int_ram_w;
            state_nxt.int_bit_pos = int_bit_w;
            // Pointer register shadows follow writes to the active bank slots
            // Shadows let indirect moves use a pointer without a RAM read
            if (i_int_req.reg_access && i_int_req.reg_index == 3'h0 && i_sfr_wr) begin
                state_nxt.pointer_zero = i_sfr_wdata;
            end
            if (i_int_req.reg_access && i_int_req.reg_index == 3'h1 && i_sfr_wr) begin
                state_nxt.pointer_one = i_sfr_wdata;
            end
        end

        // External-move access: routing fixed at its start
        // The target is latched with the request, so a control write in the same
        // cycle only affects the next move, never one already under way
        if (i_ext_req.valid) begin
            state_nxt.ext_valid = 1'b1;
            state_nxt.ext_write = i_ext_req.write;
            state_nxt.ext_target = ext_target_w;
            state_nxt.ext_addr = ext_eff_addr;
            // Gap accesses have no memory behind them, so the data is flagged undefined
            state_nxt.rdata_undefined = (ext_target_w == dmem_pkg::XT_GAP);
            if (bus_cycle) begin
                state_nxt.bus_rd_n = i_ext_req.write;
                state_nxt.bus_wr_n = !i_ext_req.write;
                state_nxt.bus_drive = 1'b1;
                state_nxt.p0_out = i_ext_req.write ? i_ext_req.wdata : ext_eff_addr[7:0];
                state_nxt.p2_out = ext_eff_addr[15:8];
            end else begin
                // Hidden on-chip or gap move: pins keep their port function
                state_nxt.bus_rd_n = 1'b1;
                state_nxt.bus_wr_n = 1'b1;
            end
        end

        // Capture external read data
        if (ext_read_done) begin
            state_nxt.ext_rdata = i_ext_rdata;
        end
    end

    // State register
    // Reset leaves the on-chip windows disabled and the stack below bank 1
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // Strobes idle high; everything else starts from its constant
            state_r <= '0;
            state_r.global_disable <= 1'b1;
            state_r.stack_pointer <= dmem_pkg::STACK_RESET;
            state_r.xdata_page_register <= dmem_pkg::XDATA_PAGE_REGISTER_RESET;
            state_r.bus_rd_n <= 1'b1;
            state_r.bus_wr_n <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register
    assign o_sfr_rdata = state_r.sfr_rdata;
    assign o_int_target = state_r.int_target;
    assign o_int_ram_addr = state_r.int_ram_addr;
    assign o_int_bit_pos = state_r.int_bit_pos;
    assign o_int_valid = state_r.int_valid;
    assign o_stack_pointer = state_r.stack_pointer;

    // External routing outputs
    assign o_ext_target = state_r.ext_target;
    assign o_ext_addr = state_r.ext_addr;
    assign o_ext_valid = state_r.ext_valid;
    assign o_ext_write = state_r.ext_write;

    // Bus pin outputs
    assign o_bus_rd_n = state_r.bus_rd_n;
    assign o_bus_wr_n = state_r.bus_wr_n;
    assign o_bus_drive = state_r.bus_drive;
    assign o_p0_out = state_r.p0_out;
    assign o_p2_out = state_r.p2_out;
    assign o_ext_rdata = state_r.ext_rdata;
    assign o_rdata_undefined = state_r.rdata_undefined;
endmodule // data_memory_decode

// ==== dmem_pkg.sv ====
// Package with constants and carrier types for the data memory decoder
package dmem_pkg;
    // Register address and system control bit layout
    localparam logic [7:0] SYSCTL_ADDR = 8'hB1;
    localparam logic [7:0] STACK_PTR_ADDR = 8'h81;
    localparam int GLOBAL_DISABLE_BIT = 0;
    localparam int VISIBLE_ACCESS_BIT = 1;
    localparam logic [7:0] SYSCTL_RESERVED_READ = 8'hFF;
    // Internal data space boundaries
    localparam logic [7:0] UPPER_HALF_BASE = 8'h80;
    localparam logic [7:0] BANK_AREA_LAST = 8'h1F;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] BIT_AREA_LAST = 8'h2F;
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam int BANK_SEL_LOW_POS = 3;
    localparam int BANK_SEL_HIGH_POS = 4;
    // External data space windows
    localparam logic [7:0] CAN_PAGE = 8'hF7;
    localparam logic [7:0] ONCHIP_XDATA_RAM_PAGE = 8'hFF;
    localparam logic [7:0] XDATA_PAGE_REGISTER_RESET = 8'h00;
    // Target of an internal data access
    typedef enum logic [1:0] {
        TGT_LOWER = 2'b00,
        TGT_UPPER = 2'b01,
        TGT_SFR = 2'b10
    } int_target_t;
    // Target of an external-move access
    typedef enum logic [1:0] {
        XT_EXTERNAL = 2'b00,
        XT_ONCHIP_XDATA_RAM = 2'b01,
        XT_CAN = 2'b10,
        XT_GAP = 2'b11
    } ext_target_t;
    // Internal data access request from the core
    typedef struct packed {
        logic valid;
        logic indirect;
        logic via_pointer;
        logic pointer_sel;
        logic bit_access;
        logic [2:0] reg_index;
        logic reg_access;
        logic [7:0] addr;
    } int_req_t;
    // External-move access request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic use_data_pointer_16;
        logic pointer_sel;
        logic [15:0] data_pointer_16;
        logic [7:0] wdata;
    } ext_req_t;
endpackage : dmem_pkg

// ==== int_addr_decode.sv ====
// Combinational decode of internal data space addresses
`timescale 1ns/1ps
module int_addr_decode (
    input wire logic [7:0] i_addr,
    input wire logic i_indirect,
    input wire logic [1:0] i_bank,
    input wire logic [2:0] i_reg_index,
    input wire logic i_reg_access,
    input wire logic i_bit_access,
    output dmem_pkg::int_target_t o_target,
    output logic [7:0] o_ram_addr,
    output logic [2:0] o_bit_pos
);
    // Register, bit and byte address forming
    always_comb begin
        o_bit_pos = 3'h0;
        if (i_reg_access) begin
            o_ram_addr = {3'h0, i_bank, i_reg_index};
        end else if (i_bit_access && !i_addr[7]) begin
            o_ram_addr = dmem_pkg::BIT_AREA_BASE | {4'h0, i_addr[6:3]};
            o_bit_pos = i_addr[2:0];
        end else begin
            o_ram_addr = i_addr;
        end
        if (o_ram_addr < dmem_pkg::UPPER_HALF_BASE) begin
            o_target = dmem_pkg::TGT_LOWER;
        end else if (i_indirect) begin
            o_target = dmem_pkg::TGT_UPPER;
        end else begin
            o_target = dmem_pkg::TGT_SFR;
        end
    end
endmodule // int_addr_decode

// ==== ext_addr_decode.sv ====
// Combinational routing of external-move effective addresses
`timescale 1ns/1ps
module ext_addr_decode (
    input wire logic [15:0] i_addr,
    input wire logic i_global_disable,
    input wire logic i_has_can,
    output dmem_pkg::ext_target_t o_target
);
    // Window decode on the high byte of the 16-bit address
    always_comb begin
        if (i_global_disable) begin
            o_target = dmem_pkg::XT_EXTERNAL;
        end else if (i_addr[15:8] == dmem_pkg::ONCHIP_XDATA_RAM_PAGE) begin
            o_target = dmem_pkg::XT_ONCHIP_XDATA_RAM;
        end else if (i_addr[15:8] == dmem_pkg::CAN_PAGE) begin
            o_target = i_has_can ? dmem_pkg::XT_CAN : dmem_pkg::XT_GAP;
        end else if (i_addr[15:8] > dmem_pkg::CAN_PAGE) begin
            o_target = dmem_pkg::XT_GAP;
        end else begin
            o_target = dmem_pkg::XT_EXTERNAL;
        end
    end
endmodule // ext_addr_decode

// ==== dmem_properties.sv ====
// Port-level assertions for the data memory decoder
`timescale 1ns/1ps
module dmem_properties (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire dmem_pkg::int_req_t i_int_req,
    input wire dmem_pkg::ext_req_t i_ext_req,
    input wire logic [7:0] i_program_status_word,
    input wire logic i_sp_push,
    input wire logic i_sp_pop,
    input wire logic i_sfr_wr,
    input wire dmem_pkg::int_target_t o_int_target,
    input wire logic [7:0] o_int_ram_addr,
    input wire logic [2:0] o_int_bit_pos,
    input wire logic o_int_valid,
    input wire logic [7:0] o_stack_pointer,
    input wire dmem_pkg::ext_target_t o_ext_target,
    input wire logic [15:0] o_ext_addr,
    input wire logic o_ext_valid,
    input wire logic o_ext_write,
    input wire logic o_bus_rd_n,
    input wire logic o_bus_wr_n,
    input wire logic o_rdata_undefined
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // Request shapes for plain upper-half and pointer moves
    sequence s_plain_high;
        i_int_req.valid && !i_int_req.reg_access && !i_int_req.bit_access && !i_int_req.via_pointer && i_int_req.addr[7];
    endsequence
    sequence s_data_pointer_16_move;
        i_ext_req.valid && i_ext_req.use_data_pointer_16;
    endsequence
    a_int_answer_next: assert property (i_int_req.valid |=> o_int_valid) else $error("no internal answer");
    a_direct_to_sfr: assert property (s_plain_high and !i_int_req.indirect |=> o_int_target == dmem_pkg::TGT_SFR)
        else $error("direct high not SPECIAL_FUNCTION_REGISTER");
    a_indirect_to_upper: assert property (s_plain_high and i_int_req.indirect |=> o_int_target == dmem_pkg::TGT_UPPER)
        else $error("indirect high not upper RAM");
    a_bank_register_map: assert property (i_int_req.valid && i_int_req.reg_access |=>
        o_int_ram_addr == {3'h0, $past(i_program_status_word[4:3]), $past(i_int_req.reg_index)})
        else $error("bank register address wrong");
    a_bit_area_map: assert property (i_int_req.valid && i_int_req.bit_access && !i_int_req.addr[7] |=>
        o_int_ram_addr == {4'h2, $past(i_int_req.addr[6:3])} && o_int_bit_pos == $past(i_int_req.addr[2:0]))
        else $error("bit address wrong");
    a_ext_answer_next: assert property (i_ext_req.valid |=> o_ext_valid && o_ext_write == $past(i_ext_req.write))
        else $error("no external answer");
    a_data_pointer_16_address: assert property (s_data_pointer_16_move |=> o_ext_addr == $past(i_ext_req.data_pointer_16))
        else $error("pointer address wrong");
    a_external_strobes: assert property (o_ext_valid && o_ext_target == dmem_pkg::XT_EXTERNAL |->
        o_bus_wr_n != o_ext_write && o_bus_rd_n == o_ext_write) else $error("external strobe wrong");
    a_gap_undefined: assert property (o_rdata_undefined |-> o_ext_valid && o_ext_target == dmem_pkg::XT_GAP)
        else $error("undefined flag outside gap");
    a_stack_push_step: assert property (i_sp_push && !i_sp_pop && !i_sfr_wr |=>
        o_stack_pointer == $past(o_stack_pointer) + 8'h01) else $error("push step wrong");
endmodule // dmem_properties

// ==== xbus_memory_model.sv ====
// Behavioural external data memory on the port 0/2 bus
`timescale 1ns/1ps
module xbus_memory_model (
    input wire logic i_clk,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [256];
    logic [7:0] last_r = 8'h00;
    // Store on write strobe, remember what was last driven
    always @(posedge i_clk) begin
        if (!i_wr_n) mem[i_addr[7:0]] <= i_wdata;
        if (!i_rd_n) last_r <= mem[i_addr[7:0]];
    end
    // Released bus shows the inverse of the last value
    assign o_rdata = !i_rd_n ? mem[i_addr[7:0]] : ~last_r;
endmodule // xbus_memory_model

// ==== tb_data_memory_decode.sv ====
// Self-checking bench for the data memory decoder
`timescale 1ns/1ps
module tb_data_memory_decode;
    logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_has_can = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    logic i_sp_push = 1'b0, i_sp_pop = 1'b0;
    dmem_pkg::int_req_t i_int_req = '0;
    dmem_pkg::ext_req_t i_ext_req = '0;
    logic [7:0] i_program_status_word = 8'h00, i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_p2_latch = 8'hA0;
    logic [7:0] i_ext_rdata, o_sfr_rdata, o_int_ram_addr, o_stack_pointer, o_p0_out, o_p2_out, o_ext_rdata;
    dmem_pkg::int_target_t o_int_target;
    dmem_pkg::ext_target_t o_ext_target;
    logic [2:0] o_int_bit_pos;
    logic [15:0] o_ext_addr;
    logic o_int_valid, o_ext_valid, o_ext_write, o_bus_rd_n, o_bus_wr_n, o_bus_drive, o_rdata_undefined;
    int check_count = 0, num_errors = 0, cycles = 0;

    data_memory_decode uut (.*);
    xbus_memory_model u_xmem (.i_clk(i_ref_clk), .i_rd_n(o_bus_rd_n), .i_wr_n(o_bus_wr_n), .i_addr(o_ext_addr),
        .i_wdata(o_p0_out), .o_rdata(i_ext_rdata));

    // Clock and cycle ceiling
    always #4 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 1000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask
    task automatic special_function_register(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        {i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_wdata} = {wr, !wr, addr, data};
        tick();
        {i_sfr_wr, i_sfr_rd} = 2'h0;
        tick();
    endtask
    task automatic ctl(input logic [7:0] exp);
        special_function_register(1'b0, dmem_pkg::SYSCTL_ADDR, 8'h00);
        chk("control", {8'h00, exp}, {8'h00, o_sfr_rdata});
    endtask
    task automatic sp(input logic up, input logic [7:0] exp);
        {i_sp_push, i_sp_pop} = {up, !up};
        tick();
        {i_sp_push, i_sp_pop} = 2'h0;
        chk("stack", {8'h00, exp}, {8'h00, o_stack_pointer});
        tick();
    endtask
    // Mode is via pointer, indirect, bit access, register access
    task automatic int_op(input logic [3:0] mode, input logic [7:0] addr, input logic [12:0] exp);
        dmem_pkg::int_req_t req;
        req = '0;
        {req.valid, req.via_pointer, req.indirect, req.bit_access, req.reg_access} = {1'b1, mode};
        {req.addr, req.reg_index} = {addr, addr[2:0]};
        i_int_req = req;
        tick();
        i_int_req.valid = 1'b0;
        chk("internal", {3'h1, exp}, {2'h0, o_int_valid, o_int_target, o_int_ram_addr, o_int_bit_pos});
        tick();
    endtask
    // Expected is target, read strobe, write strobe, undefined flag
    task automatic ext_op(input logic wr, input logic dp, input logic [15:0] addr, input logic [4:0] exp);
        dmem_pkg::ext_req_t req;
        req = '0;
        {req.valid, req.write, req.use_data_pointer_16, req.data_pointer_16, req.wdata} = {1'b1, wr, dp, addr, 8'h3C};
        i_ext_req = req;
        tick();
        i_ext_req.valid = 1'b0;
        chk("route", {11'h0, exp}, {11'h0, o_ext_target, o_bus_rd_n, o_bus_wr_n, o_rdata_undefined});
        chk("address", addr, o_ext_addr);
        chk("drive", {15'h0, exp[2:1] != 2'h3}, {15'h0, o_bus_drive});
        if (exp[2:1] != 2'h3) begin
            chk("ports", {(wr ? 8'h3C : addr[7:0]), addr[15:8]}, {o_p0_out, o_p2_out});
        end
        tick();
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge i_ref_clk);
        #1;
        i_nrst = 1'b1;
        chk("stack reset", 16'h0007, {8'h00, o_stack_pointer});
        ctl(8'hFD);
        sp(1'b1, 8'h08);
        special_function_register(1'b1, dmem_pkg::STACK_PTR_ADDR, 8'hFF);
        sp(1'b1, 8'h00);
        sp(1'b0, 8'hFF);
        $display("test reset and stack done");
        int_op(4'h0, 8'h05, {dmem_pkg::TGT_LOWER, 8'h05, 3'h0});
        int_op(4'h4, 8'h05, {dmem_pkg::TGT_LOWER, 8'h05, 3'h0});
        int_op(4'h0, 8'h90, {dmem_pkg::TGT_SFR, 8'h90, 3'h0});
        int_op(4'h4, 8'h90, {dmem_pkg::TGT_UPPER, 8'h90, 3'h0});
        for (int b = 0; b < 4; b++) begin
            i_program_status_word = {3'h0, b[1:0], 3'h0};
            int_op(4'h1, 8'h07, {dmem_pkg::TGT_LOWER, 3'h0, b[1:0], 3'h7, 3'h0});
        end
        int_op(4'h2, 8'h7F, {dmem_pkg::TGT_LOWER, 8'h2F, 3'h7});
        int_op(4'h2, 8'h00, {dmem_pkg::TGT_LOWER, 8'h20, 3'h0});
        {i_sfr_addr, i_sfr_wdata, i_sfr_wr} = {8'h00, 8'h95, 1'b1};
        int_op(4'h1, 8'h00, {dmem_pkg::TGT_LOWER, 8'h18, 3'h0});
        i_sfr_wr = 1'b0;
        int_op(4'hC, 8'h00, {dmem_pkg::TGT_UPPER, 8'h95, 3'h0});
        $display("test internal decode done");
        ext_op(1'b1, 1'b1, 16'hFF10, {dmem_pkg::XT_EXTERNAL, 3'h4});
        ext_op(1'b0, 1'b1, 16'hFF10, {dmem_pkg::XT_EXTERNAL, 3'h2});
        tick();
        chk("ext data", 16'h003C, {8'h00, o_ext_rdata});
        special_function_register(1'b1, dmem_pkg::SYSCTL_ADDR, 8'h00);
        special_function_register(1'b1, dmem_pkg::SYSCTL_ADDR, 8'h01);
        ctl(8'hFC);
        ext_op(1'b0, 1'b1, 16'hFF10, {dmem_pkg::XT_ONCHIP_XDATA_RAM, 3'h6});
        ext_op(1'b1, 1'b1, 16'hF720, {dmem_pkg::XT_CAN, 3'h6});
        ext_op(1'b0, 1'b1, 16'hF900, {dmem_pkg::XT_GAP, 3'h7});
        ext_op(1'b0, 1'b1, 16'h1234, {dmem_pkg::XT_EXTERNAL, 3'h2});
        i_has_can = 1'b0;
        ext_op(1'b0, 1'b1, 16'hF720, {dmem_pkg::XT_GAP, 3'h7});
        i_has_can = 1'b1;
        special_function_register(1'b1, dmem_pkg::SYSCTL_ADDR, 8'h02);
        ctl(8'hFE);
        ext_op(1'b1, 1'b1, 16'hFF10, {dmem_pkg::XT_ONCHIP_XDATA_RAM, 3'h4});
        ext_op(1'b0, 1'b1, 16'h1234, {dmem_pkg::XT_EXTERNAL, 3'h2});
        special_function_register(1'b1, i_p2_latch, 8'hFF);
        ext_op(1'b0, 1'b0, 16'hFF95, {dmem_pkg::XT_ONCHIP_XDATA_RAM, 3'h2});
        $display("test external routing done");
        test_done();
    end
endmodule // tb_data_memory_decode

bind data_memory_decode dmem_properties u_props (.*);
